/* shared/cmp_pkg.sv */
// constants shared by the comparator control logic
package cmp_pkg;

  // control word a: bit positions, writable mask and reset value
  localparam int CA_ON_BIT = 7;
  localparam int CA_RES_BIT = 6;
  localparam int CA_OE_BIT = 5;
  localparam int CA_POL_BIT = 4;
  localparam int CA_SP_BIT = 2;
  localparam int CA_HYS_BIT = 1;
  localparam int CA_SYNC_BIT = 0;
  localparam logic [7:0] CA_WMASK = 8'hb7;
  localparam logic [7:0] CA_RST = 8'h04; // speed_sel resets to normal speed

  // control word b: bit positions, writable mask and reset value
  localparam int CB_RISE_BIT = 7;
  localparam int CB_FALL_BIT = 6;
  localparam int CB_PCH_LSB = 4;
  localparam int CB_NCH_LSB = 0;
  localparam logic [7:0] CB_WMASK = 8'hf7;
  localparam logic [7:0] CB_RST = 8'h00;

  // widths
  localparam int POS_W = 4;
  localparam int NEG_W = 6;
  localparam int NEG_PIN_N = 4;
  localparam int PORT_W = 8;

  // non-inverting source codes
  localparam logic [1:0] POS_PIN = 2'h0;
  localparam logic [1:0] POS_DAC = 2'h1;
  localparam logic [1:0] POS_FVR = 2'h2;
  localparam logic [1:0] POS_GND = 2'h3;

  // inverting source codes; codes 6 and 7 fall back to analog ground
  localparam logic [2:0] NEG_PIN0 = 3'h0;
  localparam logic [2:0] NEG_PIN3 = 3'h3;
  localparam logic [2:0] NEG_AGND = 3'h4;
  localparam logic [2:0] NEG_FVR2 = 3'h5;
  localparam int NEG_AGND_IDX = 4;
  localparam int NEG_FVR2_IDX = 5;

endpackage

/* logic/cmp_sync2.sv */
// two-flop synchroniser for levels arriving from outside the clock domain
module cmp_sync2 #(
  parameter int W = 1
) (
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic ce_i,
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);

  logic [W-1:0] meta_q;
  logic [W-1:0] sync_q;

  // first stage feeds only the second stage
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      meta_q <= '0;
      sync_q <= '0;
    end else if (ce_i) begin
      meta_q <= d_i;
      sync_q <= meta_q;
    end
  end

  assign q_o = sync_q;

endmodule

/* logic/cmp_edge_flag.sv */
// edge detectors on the registered result and the sticky event flag
module cmp_edge_flag (
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic ce_i,
  input wire logic level_i,
  input wire logic rise_en_i,
  input wire logic fall_en_i,
  input wire logic clr_i,
  output logic rise_o,
  output logic fall_o,
  output logic flag_o
);

  logic prev_q;
  logic flag_q;
  logic set_w;

  // previous instruction cycle's result
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      prev_q <= 1'b0;
    end else if (ce_i) begin
      prev_q <= level_i;
    end
  end

  assign rise_o = level_i & ~prev_q;
  assign fall_o = ~level_i & prev_q;
  assign set_w = ce_i & ((rise_o & rise_en_i) | (fall_o & fall_en_i));

  // set wins over a clear in the same cycle
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      flag_q <= 1'b0;
    end else if (set_w) begin
      flag_q <= 1'b1;
    end else if (ce_i && clr_i) begin
      flag_q <= 1'b0;
    end
  end

  assign flag_o = flag_q;

endmodule

/* logic/cmp_ctrl.sv */
// comparator digital control: enables, polarity, pin override, sync, events
// Summary of operation
// - comparator runs only while comparator_on is set; clear means lowest current.
// - raw result is high when non-inverting input exceeds inverting input.
// - reported result is raw result, complemented when invert_sel is one.
// - adjusted result readable as cmp_result_bit and as mirror_result_bit.
// - pin driven with the result only with output enable, pin set as output, comparator on; without output enable the latch drives it if the pin is an output.
// - output enable replaces port latch on the pin; comparator_on does not.
// - internal result registered each instruction cycle; pin unlatched unless synced.
// - speed_sel resets to one, normal speed; zero selects low power.
// - hysteresis applied only while hyst_en is set.
// - result offered to gate_timer as a gate-control source.
// - with timer_sync_en, result captured on gate clock falling edge and forwarded.
// - capture uses the prescaler output when the timer uses a prescaler.
// - timer counts on rising edge, capture on falling edge, so no race.
// - rising and falling detectors set the event flag when enabled.
// - only software clears the event flag; a same-cycle edge keeps it set.
// - request goes out only with event, peripheral and global gates set.
// - detectors watch adjusted result, so polarity or enable toggles raise events.
// - two-bit pos_input_sel picks pin, reference converter, fixed reference or ground.
// - all inputs disconnected while comparator_on is clear.
// - three-bit neg_input_sel picks four pins, analog ground or second reference buffer.
// - selected inverting pin shared with an enabled amplifier takes the amplifier output.
// - port read returns zero for pins configured as analog.
module cmp_ctrl (
  input wire logic CORE_CLK_I,
  input wire logic NRST_I,
  input wire logic CLK_EN_I,
  input wire logic RAW_CMP_I,
  input wire logic GATE_CLK_I,
  input wire logic CTRL_A_WR_I,
  input wire logic [7:0] CTRL_A_DATA_I,
  input wire logic CTRL_B_WR_I,
  input wire logic [7:0] CTRL_B_DATA_I,
  input wire logic PIN_DIR_I,
  input wire logic PORT_LATCH_I,
  input wire logic [cmp_pkg::NEG_PIN_N-1:0] OPAMP_EN_I,
  input wire logic EVENT_FLAG_CLR_I,
  input wire logic EVENT_ENABLE_I,
  input wire logic PERIPH_IRQ_GATE_I,
  input wire logic GLOBAL_IRQ_GATE_I,
  input wire logic [cmp_pkg::PORT_W-1:0] PORT_PINS_I,
  input wire logic [cmp_pkg::PORT_W-1:0] ANALOG_SEL_I,
  output logic [7:0] CTRL_A_O,
  output logic [7:0] CTRL_B_O,
  output logic MIRROR_RESULT_O,
  output logic ANALOG_EN_O,
  output logic SPEED_SEL_O,
  output logic HYST_EN_O,
  output logic [cmp_pkg::POS_W-1:0] POS_SEL_O,
  output logic [cmp_pkg::NEG_W-1:0] NEG_SEL_O,
  output logic NEG_OPAMP_O,
  output logic CMP_PIN_O,
  output logic CMP_PIN_OE_O,
  output logic GATE_SRC_O,
  output logic EVENT_FLAG_O,
  output logic IRQ_REQ_O,
  output logic [cmp_pkg::PORT_W-1:0] PORT_READ_O
);
  import cmp_pkg::*;

  // one-hot decode of the non-inverting selector
  function automatic logic [POS_W-1:0] pos_onehot(input logic [1:0] code);
    logic [POS_W-1:0] v;
    v = '0;
    unique case (code)
      POS_PIN: v[0] = 1'b1;
      POS_DAC: v[1] = 1'b1;
      POS_FVR: v[2] = 1'b1;
      POS_GND: v[3] = 1'b1;
    endcase
    return v;
  endfunction

  // one-hot decode of the inverting selector; spare codes go to ground
  function automatic logic [NEG_W-1:0] neg_onehot(input logic [2:0] code);
    logic [NEG_W-1:0] v;
    v = '0;
    if (code <= NEG_PIN3) begin
      v[code[1:0]] = 1'b1;
    end else if (code == NEG_FVR2) begin
      v[NEG_FVR2_IDX] = 1'b1;
    end else begin
      v[NEG_AGND_IDX] = 1'b1;
    end
    return v;
  endfunction

  localparam int SYNC_W = PORT_W + 2;

  logic [7:0] ctrl_a_q;
  logic [7:0] ctrl_b_q;
  logic [SYNC_W-1:0] sync_w;
  logic raw_s;
  logic gate_clk_s;
  logic [PORT_W-1:0] port_s;
  logic on_w;
  logic pol_w;
  logic oe_w;
  logic sync_en_w;
  logic [1:0] pch_w;
  logic [2:0] nch_w;
  logic res_live;
  logic res_q;
  logic gate_clk_prev_q;
  logic gate_fall_w;
  logic cap_q;
  logic pin_res_w;
  logic [POS_W-1:0] pos_sel_q;
  logic [NEG_W-1:0] neg_sel_q;
  logic neg_opamp_q;
  logic [PORT_W-1:0] port_rd_q;
  logic rise_w;
  logic fall_w;
  logic flag_w;

  // analog result, gate clock and port pins all come from outside the domain
  cmp_sync2 #(
    .W(SYNC_W)
  ) u_sync (
    .clk_i(CORE_CLK_I),
    .nrst_i(NRST_I),
    .ce_i(CLK_EN_I),
    .d_i({RAW_CMP_I, GATE_CLK_I, PORT_PINS_I}),
    .q_o(sync_w)
  );

  assign raw_s = sync_w[SYNC_W-1];
  assign gate_clk_s = sync_w[SYNC_W-2];
  assign port_s = sync_w[PORT_W-1:0];

  // control words written by software, reserved bits held at zero
  always_ff @(posedge CORE_CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      ctrl_a_q <= CA_RST;
    end else if (CLK_EN_I && CTRL_A_WR_I) begin
      ctrl_a_q <= CTRL_A_DATA_I & CA_WMASK;
    end
  end

  always_ff @(posedge CORE_CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      ctrl_b_q <= CB_RST;
    end else if (CLK_EN_I && CTRL_B_WR_I) begin
      ctrl_b_q <= CTRL_B_DATA_I & CB_WMASK;
    end
  end

  // field views
  assign on_w = ctrl_a_q[CA_ON_BIT];
  assign pol_w = ctrl_a_q[CA_POL_BIT];
  assign oe_w = ctrl_a_q[CA_OE_BIT];
  assign sync_en_w = ctrl_a_q[CA_SYNC_BIT];
  assign pch_w = ctrl_b_q[CB_PCH_LSB+:2];
  assign nch_w = ctrl_b_q[CB_NCH_LSB+:3];

  // a disabled comparator reads as low before polarity, so toggling
  // comparator_on or invert_sel still moves the adjusted result
  assign res_live = (on_w & raw_s) ^ pol_w;

  // internal result latched once per instruction cycle
  always_ff @(posedge CORE_CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      res_q <= 1'b0;
    end else if (CLK_EN_I) begin
      res_q <= res_live;
    end
  end

  // readback: result bit merged into control word a and the mirror
  always_comb begin
    CTRL_A_O = ctrl_a_q;
    CTRL_A_O[CA_RES_BIT] = res_q;
  end
  assign CTRL_B_O = ctrl_b_q;
  assign MIRROR_RESULT_O = res_q;

  // analog-side enables
  assign ANALOG_EN_O = on_w;
  assign SPEED_SEL_O = ctrl_a_q[CA_SP_BIT];
  assign HYST_EN_O = on_w & ctrl_a_q[CA_HYS_BIT];

  // gate clock arrives already divided by the prescaler when one is used;
  // capturing on its falling edge keeps clear of the timer's rising count edge
  always_ff @(posedge CORE_CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      gate_clk_prev_q <= 1'b0;
    end else if (CLK_EN_I) begin
      gate_clk_prev_q <= gate_clk_s;
    end
  end

  assign gate_fall_w = gate_clk_prev_q & ~gate_clk_s;

  always_ff @(posedge CORE_CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      cap_q <= 1'b0;
    end else if (CLK_EN_I && gate_fall_w) begin
      cap_q <= res_live;
    end
  end

  // pin and timer see the live value unless sync is on; the live value
  // is only as fresh as the two-flop synchroniser allows
  assign pin_res_w = sync_en_w ? cap_q : res_live;
  assign GATE_SRC_O = pin_res_w;

  // output enable overrides the port latch regardless of comparator_on,
  // but with output enable the driver only opens with the pin set as output and comparator on
  assign CMP_PIN_O = oe_w ? pin_res_w : PORT_LATCH_I;
  assign CMP_PIN_OE_O = ~PIN_DIR_I & (~oe_w | on_w);

  // input routing, all open while the comparator is off
  always_ff @(posedge CORE_CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      pos_sel_q <= '0;
      neg_sel_q <= '0;
      neg_opamp_q <= 1'b0;
    end else if (CLK_EN_I) begin
      pos_sel_q <= on_w ? pos_onehot(pch_w) : '0;
      neg_sel_q <= on_w ? neg_onehot(nch_w) : '0;
      neg_opamp_q <= on_w && (nch_w <= NEG_PIN3) && OPAMP_EN_I[nch_w[1:0]];
    end
  end

  assign POS_SEL_O = pos_sel_q;
  assign NEG_SEL_O = neg_sel_q;
  assign NEG_OPAMP_O = neg_opamp_q;

  // port read masks analog pins to zero
  always_ff @(posedge CORE_CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      port_rd_q <= '0;
    end else if (CLK_EN_I) begin
      port_rd_q <= port_s & ~ANALOG_SEL_I;
    end
  end

  assign PORT_READ_O = port_rd_q;

  // edge detection and the sticky event flag
  cmp_edge_flag u_edge (
    .clk_i(CORE_CLK_I),
    .nrst_i(NRST_I),
    .ce_i(CLK_EN_I),
    .level_i(res_q),
    .rise_en_i(ctrl_b_q[CB_RISE_BIT]),
    .fall_en_i(ctrl_b_q[CB_FALL_BIT]),
    .clr_i(EVENT_FLAG_CLR_I),
    .rise_o(rise_w),
    .fall_o(fall_w),
    .flag_o(flag_w)
  );

  assign EVENT_FLAG_O = flag_w;

  // request needs every gate; the edge enables already qualify the flag
  assign IRQ_REQ_O = flag_w & EVENT_ENABLE_I & PERIPH_IRQ_GATE_I
                     & GLOBAL_IRQ_GATE_I;

  // ---------------- checks ----------------
  default clocking cb @(posedge CORE_CLK_I);
  endclocking
  default disable iff (!NRST_I);

  logic edge_set_w;
  assign edge_set_w = CLK_EN_I && ((rise_w && ctrl_b_q[CB_RISE_BIT])
                      || (fall_w && ctrl_b_q[CB_FALL_BIT]));

  a_flag_set_wins: assert property (edge_set_w |=> EVENT_FLAG_O)
    else $error("event flag not set after qualifying edge");

  a_flag_sticky: assert property (
    EVENT_FLAG_O && !(CLK_EN_I && EVENT_FLAG_CLR_I) |=> EVENT_FLAG_O)
    else $error("event flag dropped without a clear");

  a_flag_clear: assert property (
    CLK_EN_I && EVENT_FLAG_CLR_I && !edge_set_w |=> !EVENT_FLAG_O)
    else $error("event flag survived a clear");

  a_edge_timing: assert property (
    CLK_EN_I && ctrl_b_q[CB_RISE_BIT] && !CTRL_B_WR_I && !EVENT_FLAG_CLR_I
    && (res_live && !res_q) ##1 CLK_EN_I |=> EVENT_FLAG_O)
    else $error("rising result did not flag two cycles later");

  a_irq_gate: assert property (
    IRQ_REQ_O |-> EVENT_FLAG_O && EVENT_ENABLE_I && PERIPH_IRQ_GATE_I && GLOBAL_IRQ_GATE_I)
    else $error("request raised without all gates");

  a_result_pol: assert property (
    CLK_EN_I |=> res_q == (($past(raw_s) & $past(on_w)) ^ $past(pol_w)))
    else $error("registered result has wrong polarity");

  a_mirror_match: assert property (CTRL_A_O[CA_RES_BIT] == MIRROR_RESULT_O)
    else $error("mirror and control result differ");

  a_pin_drive: assert property (CMP_PIN_OE_O && oe_w |-> on_w && !PIN_DIR_I)
    else $error("pin driven with comparator result while not allowed");

  a_pin_override: assert property (oe_w && !sync_en_w |-> CMP_PIN_O == res_live)
    else $error("pin does not carry live result under override");

  a_sync_capture: assert property (
    CLK_EN_I && gate_fall_w |=> cap_q == $past(res_live))
    else $error("result not captured on gate clock falling edge");

  // with sync on, the forwarded value only moves after a gate clock fall
  a_gate_hold: assert property (
    CLK_EN_I && sync_en_w && !gate_fall_w |=> !sync_en_w || $stable(GATE_SRC_O))
    else $error("synced result changed without a gate clock fall");

  a_inputs_off: assert property (
    CLK_EN_I && !on_w |=> POS_SEL_O == '0 && NEG_SEL_O == '0 && !NEG_OPAMP_O)
    else $error("inputs connected while comparator off");

  // routing follows the select field one cycle later
  a_pos_route: assert property (
    CLK_EN_I && on_w |=> $onehot(POS_SEL_O) && POS_SEL_O[$past(pch_w)])
    else $error("non-inverting select not routed to its source");

  a_neg_route: assert property (
    CLK_EN_I && on_w && nch_w <= NEG_PIN3 |=> $onehot(NEG_SEL_O)
    && NEG_SEL_O[$past(nch_w)])
    else $error("inverting pin select not routed to its pin");

  a_opamp_spare: assert property (
    CLK_EN_I && nch_w > NEG_PIN3 |=> !NEG_OPAMP_O)
    else $error("amplifier routed without an inverting pin selected");

  a_neg_spare: assert property (
    CLK_EN_I && on_w && nch_w > NEG_FVR2 |=> NEG_SEL_O[NEG_AGND_IDX] && $onehot(NEG_SEL_O))
    else $error("spare inverting code not routed to ground");

  a_hyst_gate: assert property (
    HYST_EN_O == (on_w && ctrl_a_q[CA_HYS_BIT]))
    else $error("hysteresis enable does not follow its bit");

  a_pin_input: assert property (
    PIN_DIR_I |-> !CMP_PIN_OE_O)
    else $error("pin driver open while pin set as input");

  a_analog_mask: assert property (
    CLK_EN_I |=> (PORT_READ_O & $past(ANALOG_SEL_I)) == '0)
    else $error("analog pin read as one");

  c_rise_flag: cover property (rise_w && ctrl_b_q[CB_RISE_BIT] ##1 EVENT_FLAG_O);
  c_fall_flag: cover property (fall_w && ctrl_b_q[CB_FALL_BIT] ##1 EVENT_FLAG_O);
  c_clear_race: cover property (edge_set_w && EVENT_FLAG_CLR_I);
  c_sync_cap: cover property (sync_en_w && gate_fall_w);
  c_off_toggle: cover property (!on_w && $changed(pol_w) ##2 EVENT_FLAG_O);

endmodule

/* testbench/cmp_gate_model.sv */
// gate timer model: prescaled gate clock and a count gated by the comparator
module cmp_gate_model #(
  parameter int PRESC = 4
) (
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic run_i,
  input wire logic gate_i,
  output logic gate_clk_o,
  output logic [15:0] count_o
);
  timeunit 1ns;
  timeprecision 1ps;
  int div_q;
  // the design only sees the divided clock; it stands still high while idle
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      div_q <= 0;
      gate_clk_o <= 1'b1;
    end else if (run_i) begin
      div_q <= (div_q == PRESC - 1) ? 0 : div_q + 1;
      if (div_q == PRESC - 1) begin
        gate_clk_o <= ~gate_clk_o;
      end
    end else begin
      div_q <= 0;
      gate_clk_o <= 1'b1;
    end
  end
  // count on the rising edge, opposite to the falling-edge capture, so no race
  always_ff @(posedge gate_clk_o or negedge nrst_i) begin
    if (!nrst_i) begin
      count_o <= 16'h0000;
    end else if (gate_i) begin
      count_o <= count_o + 16'h0001;
    end
  end
endmodule

/* testbench/comparator_digital_control_bench.sv */
// self-checking bench for the comparator control block
module comparator_digital_control_bench;
  timeunit 1ns;
  timeprecision 1ps;
  import cmp_pkg::*;
  logic clk, nrst, wr_a, wr_b, raw, dir, latch, clr, ev_en, pg, gg, run, ce;
  logic [15:0] tcnt;
  logic mir, aen, spd, hyst, nop, pin, pin_oe, gsrc, flag, irq, gclk;
  logic [7:0] da, db, pins, asel, ca, cb, pread;
  logic [3:0] amp;
  logic [POS_W-1:0] psel;
  logic [NEG_W-1:0] nsel;
  int miscompares, checks, seed, cyc_n, k, n, a_m, raw_m, c0;

  cmp_ctrl dut_u (.CORE_CLK_I(clk), .NRST_I(nrst), .CLK_EN_I(ce), .RAW_CMP_I(raw),
    .GATE_CLK_I(gclk), .CTRL_A_WR_I(wr_a), .CTRL_A_DATA_I(da), .CTRL_B_WR_I(wr_b),
    .CTRL_B_DATA_I(db), .PIN_DIR_I(dir), .PORT_LATCH_I(latch), .OPAMP_EN_I(amp),
    .EVENT_FLAG_CLR_I(clr), .EVENT_ENABLE_I(ev_en), .PERIPH_IRQ_GATE_I(pg),
    .GLOBAL_IRQ_GATE_I(gg), .PORT_PINS_I(pins), .ANALOG_SEL_I(asel), .CTRL_A_O(ca),
    .CTRL_B_O(cb), .MIRROR_RESULT_O(mir), .ANALOG_EN_O(aen), .SPEED_SEL_O(spd),
    .HYST_EN_O(hyst), .POS_SEL_O(psel), .NEG_SEL_O(nsel), .NEG_OPAMP_O(nop),
    .CMP_PIN_O(pin), .CMP_PIN_OE_O(pin_oe), .GATE_SRC_O(gsrc), .EVENT_FLAG_O(flag),
    .IRQ_REQ_O(irq), .PORT_READ_O(pread));

  cmp_gate_model #(.PRESC(4)) gate_u (.clk_i(clk), .nrst_i(nrst), .run_i(run),
    .gate_i(gsrc), .gate_clk_o(gclk), .count_o(tcnt));

  // adjusted result model: a disabled comparator reads raw 0 before polarity
  function automatic int exp_res(int a, int r);
    return ((a >> 7) & 1) ? (r ^ ((a >> 4) & 1)) : ((a >> 4) & 1);
  endfunction

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chkb(input logic got, input logic exp);
    chk({7'h00, got}, {7'h00, exp});
  endtask
  // sample one step after the edge so the edge's updates have landed
  task automatic tick(input int c);
    repeat (c) @(posedge clk);
    #1;
  endtask
  task automatic wr(input int which, input int d);
    @(posedge clk);
    if (which == 0) begin
      wr_a <= 1'b1;
      da <= d[7:0];
      a_m = d & 8'hb7;
    end else begin
      wr_b <= 1'b1;
      db <= d[7:0];
    end
    @(posedge clk);
    wr_a <= 1'b0;
    wr_b <= 1'b0;
    tick(5);
  endtask
  // raw passes two synchroniser flops and a result register before the flag
  task automatic setraw(input int r);
    @(posedge clk);
    raw <= r[0];
    raw_m = r & 1;
    tick(6);
  endtask
  task automatic clear_flag();
    @(posedge clk);
    clr <= 1'b1;
    @(posedge clk);
    clr <= 1'b0;
    tick(2);
  endtask
  task automatic chk_res();
    int r;
    r = exp_res(a_m, raw_m);
    chk(ca, 8'(a_m | (r << 6)));
    chkb(mir, r != 0);
  endtask
  task automatic final_report();
    $display("checks=%0d miscompares=%0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  // a hang ends the run as a failure
  always @(posedge clk) begin
    cyc_n++;
    if (cyc_n == 5000) begin
      miscompares++;
      final_report();
    end
  end

  initial begin
    {wr_a, wr_b, raw, dir, latch, clr, ev_en, pg, gg, run, nrst} = '0;
    {da, db, pins, asel} = '0;
    ce = 1'b1;
    amp = 4'h5;
    miscompares = 0;
    checks = 0;
    cyc_n = 0;
    seed = 29;
    a_m = 8'h04;
    raw_m = 0;
    repeat (16) @(posedge clk);
    nrst <= 1'b1;
    tick(2);
    chk(ca, 8'h04);
    chk(cb, 8'h00);
    chkb(spd, 1'b1);
    chkb(pin_oe, 1'b1);
    // clock enable low freezes state: this write must not land
    @(posedge clk);
    ce <= 1'b0;
    raw <= 1'b1;
    wr(0, 8'h90);
    chk(ca, 8'h04);
    @(posedge clk);
    ce <= 1'b1;
    raw <= 1'b0;
    a_m = 8'h04;
    tick(3);
    chk(ca, 8'h04);
    chkb(aen, 1'b0);
    // every mix of enable, polarity and hysteresis with a random raw level
    for (k = 0; k < 8; k++) begin
      wr(0, 8'h04 | ((k >> 2) << 7) | (((k >> 1) & 1) << 4) | ((k & 1) << 1));
      setraw($random(seed));
      chk_res();
      chkb(aen, k >= 4);
      chkb(hyst, k == 5 || k == 7);
      chkb(gsrc, exp_res(a_m, raw_m) != 0);
    end
    wr(0, 8'hff);
    chk_res();
    chkb(spd, 1'b1);
    wr(0, 8'h80);
    chkb(spd, 1'b0);
    // pin override against a latch that disagrees with the result
    @(posedge clk);
    latch <= 1'b1;
    setraw(0);
    wr(0, 8'ha0);
    chkb(pin, 1'b0);
    chkb(pin_oe, 1'b1);
    wr(0, 8'h20);
    chkb(pin_oe, 1'b0);
    chkb(pin, 1'b0);
    wr(0, 8'h80);
    chkb(pin, 1'b1);
    @(posedge clk);
    dir <= 1'b1;
    tick(1);
    chkb(pin_oe, 1'b0);
    // synced mode: result held between gate clock falling edges
    wr(0, 8'ha1);
    c0 = tcnt;
    @(posedge clk);
    run <= 1'b1;
    tick(40);
    run <= 1'b0;
    tick(10);
    // gate source low the whole run, so the timer must not have counted
    chkb(tcnt == 16'(c0), 1'b1);
    setraw(1);
    tick(4);
    chkb(gsrc, 1'b0);
    chkb(pin, 1'b0);
    chkb(mir, 1'b1);
    c0 = tcnt;
    @(posedge clk);
    run <= 1'b1;
    tick(40);
    chkb(gsrc, 1'b1);
    chkb(tcnt != 16'(c0), 1'b1);
    run <= 1'b0;
    // every input select code, then all inputs cut when disabled
    for (k = 0; k < 32; k++) begin
      n = k & 7;
      wr(1, ((k >> 3) << 4) | n);
      chk(cb, 8'(((k >> 3) << 4) | n));
      chk(8'(psel), 8'(1 << (k >> 3)));
      chk(8'(nsel), 8'((n > 5) ? 16 : (1 << n)));
      chkb(nop, n < 4 && ((amp >> n) & 1));
    end
    wr(0, 8'h00);
    chk(8'(psel), 8'h00);
    chk(8'(nsel), 8'h00);
    // random pin levels and analog masks
    repeat (4) begin
      @(posedge clk);
      pins <= 8'($random(seed));
      asel <= 8'($random(seed));
      tick(5);
      chk(pread, pins & ~asel);
    end
    // edge events, gating and software clear
    @(posedge clk);
    {ev_en, pg, gg} <= 3'b111;
    wr(0, 8'h80);
    wr(1, 8'h80);
    setraw(0);
    clear_flag();
    chkb(flag, 1'b0);
    setraw(1);
    chkb(flag, 1'b1);
    chkb(irq, 1'b1);
    @(posedge clk);
    gg <= 1'b0;
    tick(1);
    chkb(irq, 1'b0);
    chkb(flag, 1'b1);
    clear_flag();
    chkb(flag, 1'b0);
    setraw(0);
    chkb(flag, 1'b0);
    wr(0, 8'h10);
    tick(3);
    chkb(flag, 1'b1);
    final_report();
  end
endmodule
